//--- cea_cfg.svh
`ifndef CEA_CFG_SVH
`define CEA_CFG_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CEA_ADDR_W 16
`define CEA_DATA_W 8
`define CEA_FLAG_W 5

// ----------------------------------------------------------------------------
// Condition flag bit positions
// ----------------------------------------------------------------------------
`define CEA_FLAG_H 4
`define CEA_FLAG_I 3
`define CEA_FLAG_N 2
`define CEA_FLAG_Z 1
`define CEA_FLAG_C 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CEA_PC_RESET 16'h0000
`define CEA_FLAGS_RESET 5'h08
`define CEA_BYTE_ZERO 8'h00

// ----------------------------------------------------------------------------
// Instruction lengths in bytes, opcode included
// ----------------------------------------------------------------------------
`define CEA_LEN_ONE 16'h0001
`define CEA_LEN_TWO 16'h0002
`define CEA_LEN_THREE 16'h0003

`endif

//--- cea_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "cea_cfg.svh"

module cea_core (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Instruction request
   input wire logic i_start,
   input wire cea_pkg::cea_mode_t i_mode,
   input wire cea_pkg::cea_access_t i_access,
   input wire logic [`CEA_DATA_W-1:0] i_store_data,
   input wire logic [`CEA_DATA_W-1:0] i_index,
   // Program counter load
   input wire logic i_pc_load,
   input wire logic [`CEA_ADDR_W-1:0] i_pc_value,
   // Memory read data, one cycle after a read request
   input wire logic [`CEA_DATA_W-1:0] i_rdata,
   // Flag update
   input wire logic i_flag_valid,
   input wire cea_pkg::cea_flag_req_t i_flag_req,
   // Memory request
   output cea_pkg::cea_mem_req_t o_mem,
   // Instruction status
   output logic o_busy,
   output logic o_done,
   output logic [`CEA_ADDR_W-1:0] o_program_counter,
   output cea_pkg::cea_addr_t o_operand_address,
   output logic [`CEA_DATA_W-1:0] o_operand,
   output logic [`CEA_DATA_W-1:0] o_branch_byte,
   // Flags
   output logic [`CEA_FLAG_W-1:0] o_condition_flags,
   output logic [`CEA_DATA_W-1:0] o_result
);
   import cea_pkg::*;

   // ------------------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_BYTE1,
      ST_BYTE2,
      ST_ADDR,
      ST_OPER,
      ST_DATA,
      ST_DONE
   } cea_state_t;

   cea_state_t state_reg;
   cea_state_t state_next;
   cea_mode_t mode_reg;
   cea_access_t access_reg;
   logic [`CEA_DATA_W-1:0] wdata_reg;
   logic [`CEA_DATA_W-1:0] byte1_reg;
   logic [`CEA_ADDR_W-1:0] pc_reg;
   cea_addr_t ea_reg;
   cea_addr_t ea_calc;
   cea_mem_req_t mem_reg;
   cea_mem_req_t mem_next;
   logic [`CEA_DATA_W-1:0] operand_reg;
   logic [`CEA_DATA_W-1:0] branch_reg;
   logic busy_reg;
   logic done_reg;
   logic [`CEA_FLAG_W-1:0] flags_reg;
   logic [`CEA_FLAG_W-1:0] flags_next;
   logic [`CEA_DATA_W-1:0] result_reg;
   logic [`CEA_DATA_W-1:0] result_next;
   logic [`CEA_DATA_W-1:0] hi_byte;
   logic [`CEA_DATA_W-1:0] lo_byte;
   logic [8:0] idx_sum9;
   logic [`CEA_ADDR_W-1:0] idx_sum16;

   // ------------------------------------------------------------------------
   // Mode properties.
   // ------------------------------------------------------------------------
   // Count of bytes after the opcode that must be fetched first; for bit_test_branch_mode the second is the branch byte.
   function automatic logic [1:0] fetch_count(input cea_mode_t m);
      unique case (m)
         direct_mode, bit_modify_mode, pointer_byte_offset_mode: fetch_count = 2'h1;
         full_address_mode, pointer_word_offset_mode, bit_test_branch_mode: fetch_count = 2'h2;
         default: fetch_count = 2'h0;
      endcase
   endfunction : fetch_count

   // Whole length in bytes; the longest form is three bytes.
   function automatic logic [`CEA_ADDR_W-1:0] instr_len(input cea_mode_t m);
      unique case (m)
         implied_mode, pointer_mode: instr_len = `CEA_LEN_ONE;
         full_address_mode, pointer_word_offset_mode,
         bit_test_branch_mode: instr_len = `CEA_LEN_THREE;
         default: instr_len = `CEA_LEN_TWO;
      endcase
   endfunction : instr_len

   // ------------------------------------------------------------------------
   // Operand address formation.
   // ------------------------------------------------------------------------
   // The last fetched byte is taken straight from the read data, so the
   // address is ready one cycle earlier than if it were stored first.
   always_comb begin
      hi_byte = (fetch_count(mode_reg) == 2'h2) ? byte1_reg : `CEA_BYTE_ZERO;
      lo_byte = i_rdata;
      idx_sum9 = {1'b0, i_index} + {1'b0, lo_byte};
      idx_sum16 = {hi_byte, lo_byte} + {`CEA_BYTE_ZERO, i_index};
      unique case (mode_reg)
         implied_mode: ea_calc = pc_reg;
         literal_operand_mode, branch_offset_mode: ea_calc = pc_reg + `CEA_LEN_ONE;
         direct_mode, bit_modify_mode: ea_calc = {`CEA_BYTE_ZERO, lo_byte};
         full_address_mode: ea_calc = {byte1_reg, lo_byte};
         pointer_mode: ea_calc = {`CEA_BYTE_ZERO, i_index};
         pointer_byte_offset_mode: ea_calc = {7'h00, idx_sum9};
         pointer_word_offset_mode: ea_calc = idx_sum16;
         bit_test_branch_mode: ea_calc = {`CEA_BYTE_ZERO, byte1_reg};
         default: ea_calc = pc_reg;
      endcase
   end

   // ------------------------------------------------------------------------
   // Sequencer.
   // ------------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (i_start) begin
               state_next = (fetch_count(i_mode) == 2'h0) ? ST_ADDR : ST_BYTE1;
            end
         end
         ST_BYTE1: state_next = (fetch_count(mode_reg) == 2'h2) ? ST_BYTE2 : ST_ADDR;
         ST_BYTE2: state_next = ST_ADDR;
         ST_ADDR: state_next = (access_reg == ACC_NONE) ? ST_DONE : ST_OPER;
         ST_OPER: state_next = (access_reg == ACC_READ) ? ST_DATA : ST_DONE;
         ST_DATA: state_next = ST_DONE;
         ST_DONE: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_reg <= (state_next != ST_IDLE);
         done_reg <= (state_next == ST_DONE);
      end
   end

   // ------------------------------------------------------------------------
   // Request capture.
   // ------------------------------------------------------------------------
   // Implied mode carries no operand, so any access asked for is dropped.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mode_reg <= implied_mode;
         access_reg <= ACC_NONE;
         wdata_reg <= `CEA_BYTE_ZERO;
      end else if (state_reg == ST_IDLE && i_start) begin
         mode_reg <= i_mode;
         access_reg <= (i_mode == implied_mode) ? ACC_NONE : i_access;
         wdata_reg <= i_store_data;
      end
   end

   // ------------------------------------------------------------------------
   // Memory request, registered so the bus sees clean levels.
   // ------------------------------------------------------------------------
   always_comb begin
      mem_next = '0;
      unique case (state_next)
         ST_BYTE1: begin
            mem_next.addr = pc_reg + `CEA_LEN_ONE;
            mem_next.rd = 1'b1;
         end
         ST_BYTE2: begin
            mem_next.addr = pc_reg + `CEA_LEN_TWO;
            mem_next.rd = 1'b1;
         end
         ST_OPER: begin
            mem_next.addr = ea_calc;
            mem_next.rd = (access_reg == ACC_READ);
            mem_next.wr = (access_reg == ACC_WRITE);
            mem_next.wdata = wdata_reg;
         end
         default: mem_next = '0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mem_reg <= '0;
      end else begin
         mem_reg <= mem_next;
      end
   end

   // ------------------------------------------------------------------------
   // Fetched bytes, operand address and operand.
   // ------------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         byte1_reg <= `CEA_BYTE_ZERO;
         ea_reg <= '0;
         operand_reg <= `CEA_BYTE_ZERO;
         branch_reg <= `CEA_BYTE_ZERO;
      end else begin
         if (state_reg == ST_BYTE2) begin
            byte1_reg <= i_rdata;
         end
         if (state_reg == ST_ADDR) begin
            ea_reg <= ea_calc;
            if (mode_reg == bit_test_branch_mode) begin
               branch_reg <= i_rdata;
            end
         end
         if (state_reg == ST_DATA) begin
            operand_reg <= i_rdata;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Program counter.
   // ------------------------------------------------------------------------
   // A load is only taken while idle, so a jump can never tear an
   // instruction that is still fetching its bytes.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pc_reg <= `CEA_PC_RESET;
      end else if (state_reg == ST_DONE) begin
         pc_reg <= pc_reg + instr_len(mode_reg);
      end else if (state_reg == ST_IDLE && i_pc_load && !i_start) begin
         pc_reg <= i_pc_value;
      end
   end

   // ------------------------------------------------------------------------
   // Condition flags.
   // ------------------------------------------------------------------------
   cea_flag_unit u_flags (
      .i_req(i_flag_req),
      .i_flags(flags_reg),
      .o_flags_next(flags_next),
      .o_result(result_next)
   );

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flags_reg <= `CEA_FLAGS_RESET;
         result_reg <= `CEA_BYTE_ZERO;
      end else if (i_flag_valid) begin
         flags_reg <= flags_next;
         result_reg <= result_next;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------------------
   assign o_mem = mem_reg;
   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_program_counter = pc_reg;
   assign o_operand_address = ea_reg;
   assign o_operand = operand_reg;
   assign o_branch_byte = branch_reg;
   assign o_condition_flags = flags_reg;
   assign o_result = result_reg;

endmodule : cea_core
`default_nettype wire

//--- cea_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "cea_cfg.svh"

// ----------------------------------------------------------------------------
// Checker for the address former and flag unit
// ----------------------------------------------------------------------------
module cea_core_sva (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Instruction and flag inputs
   input wire logic i_start,
   input wire cea_pkg::cea_mode_t i_mode,
   input wire logic [`CEA_DATA_W-1:0] i_store_data,
   input wire logic [`CEA_DATA_W-1:0] i_index,
   input wire logic i_flag_valid,
   input wire cea_pkg::cea_flag_req_t i_flag_req,
   // Design outputs
   input wire cea_pkg::cea_mem_req_t o_mem,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic [`CEA_ADDR_W-1:0] o_program_counter,
   input wire cea_pkg::cea_addr_t o_operand_address,
   input wire logic [`CEA_FLAG_W-1:0] o_condition_flags,
   input wire logic [`CEA_DATA_W-1:0] o_result
);
   import cea_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   cea_mode_t mode_q;
   logic [15:0] pc_q;
   logic [7:0] data_q;
   logic [4:0] h_sum;
   logic [8:0] c_sum;
   wire logic take = i_start && !o_busy;
   wire logic upd = i_flag_valid && !i_flag_req.restore;

   // The finish is judged against what was taken, since inputs may move while busy.
   always_ff @(posedge i_clk) begin
      if (take) begin
         mode_q <= i_mode;
         pc_q <= o_program_counter;
         data_q <= i_store_data;
      end
   end

   // Reference sums for the carry out of bit 3 and bit 7.
   assign h_sum = {1'b0, i_flag_req.op_a[3:0]} + {1'b0, i_flag_req.op_b[3:0]} +
                  {4'h0, i_flag_req.carry_in};
   assign c_sum = {1'b0, i_flag_req.op_a} + {1'b0, i_flag_req.op_b} +
                  {8'h00, i_flag_req.carry_in};

   function automatic logic [15:0] len_of(input cea_mode_t m);
      case (m)
         implied_mode, pointer_mode: return `CEA_LEN_ONE;
         full_address_mode, pointer_word_offset_mode, bit_test_branch_mode: return `CEA_LEN_THREE;
         default: return `CEA_LEN_TWO;
      endcase
   endfunction : len_of

   sequence s_take_implied;
      take && i_mode == implied_mode;
   endsequence
   sequence s_quiet_bus;
      !o_mem.rd && !o_mem.wr;
   endsequence

   chk_len_bound: assert property (take |-> ##[2:6] o_done)
      else $error("Instruction did not finish within 2 to 6 cycles.");
   chk_implied_quiet: assert property (s_take_implied |-> ##1 s_quiet_bus ##1 (s_quiet_bus and o_done))
      else $error("Implied instruction touched memory or missed its finish.");
   chk_pc_advance: assert property (o_done |=> o_program_counter == pc_q + len_of(mode_q))
      else $error("Program counter advanced by the wrong length.");
   chk_literal_addr: assert property (o_done && mode_q == literal_operand_mode |-> o_operand_address == pc_q + 16'h0001)
      else $error("Literal operand address is not counter plus one.");
   chk_direct_page: assert property (o_done && mode_q == direct_mode |-> o_operand_address.hi == 8'h00)
      else $error("Direct address high byte not zero.");
   chk_pointer_addr: assert property (o_done && mode_q == pointer_mode |-> o_operand_address == {8'h00, i_index})
      else $error("Pointer address differs from the index register.");
   chk_write_addr: assert property (o_mem.wr |-> o_mem.addr == o_operand_address && o_mem.wdata == data_q)
      else $error("Store used another address or data.");
   chk_half_carry: assert property (upd && i_flag_req.test_mask[`CEA_FLAG_H] |=> o_condition_flags[`CEA_FLAG_H] == $past(h_sum[4]))
      else $error("Half carry differs from the bit 3 carry.");
   chk_zero_flag: assert property (upd && i_flag_req.test_mask[`CEA_FLAG_Z] |=> o_condition_flags[`CEA_FLAG_Z] == (o_result == 8'h00))
      else $error("Zero flag disagrees with the result.");
   chk_add_carry: assert property (upd && i_flag_req.test_mask[`CEA_FLAG_C] && i_flag_req.kind == ALU_ADD |=> o_condition_flags[`CEA_FLAG_C] == $past(c_sum[8]))
      else $error("Carry differs from the addition carry.");
   chk_flags_hold: assert property (!i_flag_valid |=> $stable(o_condition_flags))
      else $error("Flags changed without an update.");
   chk_mask_keep: assert property (upd && !i_flag_req.set_mask[`CEA_FLAG_I] && !i_flag_req.clr_mask[`CEA_FLAG_I] |=> $stable(o_condition_flags[`CEA_FLAG_I]))
      else $error("Interrupt mask changed without being named.");
   chk_restore_all: assert property (i_flag_valid && i_flag_req.restore |=> o_condition_flags == $past(i_flag_req.stacked))
      else $error("Restored flags differ from the stacked value.");
endmodule : cea_core_sva

bind cea_core cea_core_sva u_sva (.i_clk, .i_rst_n, .i_start, .i_mode, .i_store_data, .i_index,
   .i_flag_valid, .i_flag_req, .o_mem, .o_busy, .o_done, .o_program_counter,
   .o_operand_address, .o_condition_flags, .o_result);
`default_nettype wire

//--- cea_flag_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "cea_cfg.svh"

module cea_flag_unit (
   // Request and current flags
   input wire cea_pkg::cea_flag_req_t i_req,
   input wire logic [`CEA_FLAG_W-1:0] i_flags,
   // Next flags and result
   output logic [`CEA_FLAG_W-1:0] o_flags_next,
   output logic [`CEA_DATA_W-1:0] o_result
);
   import cea_pkg::*;

   logic [8:0] sum9;
   logic [8:0] diff9;
   logic [4:0] half5;
   logic carry;
   logic [`CEA_FLAG_W-1:0] computed;

   // ------------------------------------------------------------------------
   // Arithmetic, carry and half carry.
   // ------------------------------------------------------------------------
   // The ninth bit of the difference is the borrow, so one flag serves both.
   always_comb begin
      sum9 = {1'b0, i_req.op_a} + {1'b0, i_req.op_b} + {8'h00, i_req.carry_in};
      diff9 = {1'b0, i_req.op_a} - {1'b0, i_req.op_b} - {8'h00, i_req.carry_in};
      half5 = {1'b0, i_req.op_a[3:0]} + {1'b0, i_req.op_b[3:0]} + {4'h0, i_req.carry_in};
      unique case (i_req.kind)
         ALU_ADD: begin
            o_result = sum9[7:0];
            carry = sum9[8];
         end
         ALU_SUB: begin
            o_result = diff9[7:0];
            carry = diff9[8];
         end
         default: begin
            o_result = i_req.other_result;
            carry = i_req.other_carry;
         end
      endcase
   end

   // ------------------------------------------------------------------------
   // Tested values of each flag.
   // ------------------------------------------------------------------------
   always_comb begin
      computed = i_flags;
      computed[`CEA_FLAG_H] = half5[4];
      computed[`CEA_FLAG_N] = o_result[7];
      computed[`CEA_FLAG_Z] = (o_result == `CEA_BYTE_ZERO);
      computed[`CEA_FLAG_C] = carry;
   end

   // ------------------------------------------------------------------------
   // Per-bit selection: stacked, tested, forced or kept.
   // ------------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < `CEA_FLAG_W; k = k + 1) begin : g_flag
         always_comb begin
            if (i_req.restore) begin
               o_flags_next[k] = i_req.stacked[k];
            end else if (i_req.test_mask[k]) begin
               o_flags_next[k] = computed[k];
            end else if (i_req.set_mask[k]) begin
               o_flags_next[k] = 1'b1;
            end else if (i_req.clr_mask[k]) begin
               o_flags_next[k] = 1'b0;
            end else begin
               o_flags_next[k] = i_flags[k];
            end
         end
      end
   endgenerate

endmodule : cea_flag_unit
`default_nettype wire

//--- cea_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Program and data memory seen across the address bus
// ----------------------------------------------------------------------------
module cea_mem_model (
   // Clock
   input wire logic i_clk,
   // Request from the core
   input wire cea_pkg::cea_mem_req_t i_mem,
   // Read data and last store seen
   output logic [7:0] o_rdata,
   output cea_pkg::cea_addr_t o_wr_addr,
   output logic [7:0] o_wr_data
);
   import cea_pkg::*;

   // Contents are a fixed pattern of the address, so neighbours differ except 16'h7fff/16'h8000 and 16'hffff/16'h0000.
   function automatic logic [7:0] content(input logic [15:0] a);
      return a[15:8] ^ {a[6:0], a[7]} ^ 8'h3c;
   endfunction : content

   initial begin
      o_rdata = 8'h5a;
      o_wr_addr = '0;
      o_wr_data = 8'h00;
   end

   // One cycle read latency; outside that cycle the lines toggle, so a late sample is caught.
   always @(posedge i_clk) begin
      if (i_mem.rd) begin
         o_rdata <= content(i_mem.addr);
      end else begin
         o_rdata <= ~o_rdata;
      end
      if (i_mem.wr) begin
         o_wr_addr <= i_mem.addr;
         o_wr_data <= i_mem.wdata;
      end
   end
endmodule : cea_mem_model
`default_nettype wire

//--- cea_pkg.sv
`include "cea_cfg.svh"
`default_nettype none

package cea_pkg;

   // -------------------------------------------------------------------------
   // Operand addressing schemes.
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      implied_mode,
      literal_operand_mode,
      direct_mode,
      full_address_mode,
      pointer_mode,
      pointer_byte_offset_mode,
      pointer_word_offset_mode,
      branch_offset_mode,
      bit_modify_mode,
      bit_test_branch_mode
   } cea_mode_t;

   // -------------------------------------------------------------------------
   // Operand access kind and flag arithmetic kind.
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ACC_NONE,
      ACC_READ,
      ACC_WRITE
   } cea_access_t;

   typedef enum logic [1:0] {
      ALU_ADD,
      ALU_SUB,
      ALU_OTHER
   } cea_alu_kind_t;

   // -------------------------------------------------------------------------
   // Bundles.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } cea_addr_t;

   typedef struct packed {
      cea_addr_t addr;
      logic rd;
      logic wr;
      logic [`CEA_DATA_W-1:0] wdata;
   } cea_mem_req_t;

   typedef struct packed {
      logic restore;
      logic [`CEA_FLAG_W-1:0] stacked;
      logic [`CEA_FLAG_W-1:0] test_mask;
      logic [`CEA_FLAG_W-1:0] set_mask;
      logic [`CEA_FLAG_W-1:0] clr_mask;
      cea_alu_kind_t kind;
      logic [`CEA_DATA_W-1:0] op_a;
      logic [`CEA_DATA_W-1:0] op_b;
      logic carry_in;
      logic [`CEA_DATA_W-1:0] other_result;
      logic other_carry;
   } cea_flag_req_t;

endpackage : cea_pkg
`default_nettype wire

//--- cpu_effective_address_and_flags_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cea_cfg.svh"

// ----------------------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------------------
module cpu_effective_address_and_flags_tb_top;
   import cea_pkg::*;
   logic i_clk, i_rst_n, i_start, i_pc_load, i_flag_valid, o_busy, o_done;
   cea_mode_t i_mode;
   cea_access_t i_access;
   logic [7:0] i_store_data, i_index, i_rdata, o_operand, o_result, wr_data;
   logic [15:0] i_pc_value, o_program_counter;
   cea_flag_req_t i_flag_req;
   cea_mem_req_t o_mem;
   cea_addr_t o_operand_address, wr_addr;
   logic [4:0] o_condition_flags;
   int n_errors = 0;
   int tests_run = 0;

   cea_core dut (.i_clk, .i_rst_n, .i_start, .i_mode, .i_access, .i_store_data, .i_index,
      .i_pc_load, .i_pc_value, .i_rdata, .i_flag_valid, .i_flag_req, .o_mem, .o_busy,
      .o_done, .o_program_counter, .o_operand_address, .o_operand, .o_branch_byte(),
      .o_condition_flags, .o_result);
   cea_mem_model u_mem (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_rdata),
      .o_wr_addr(wr_addr), .o_wr_data(wr_data));

   // Free running 40 ns clock.
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Independent copy of the memory pattern for expectations.
   function automatic logic [7:0] memf(input logic [15:0] a);
      return a[15:8] ^ {a[6:0], a[7]} ^ 8'h3c;
   endfunction : memf

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One instruction from a loaded counter; expectations come from mode, access and memory.
   task automatic run(input cea_mode_t m, input cea_access_t acc, input logic [15:0] pc,
                      input logic [7:0] idx, input logic [7:0] sd);
      logic [15:0] ea;
      int fetch;
      int len;
      int n;
      ea = pc + 16'h0001;
      fetch = 0;
      len = 2;
      case (m)
         implied_mode: len = 1;
         direct_mode, bit_modify_mode: begin
            ea = {8'h00, memf(pc + 16'h0001)};
            fetch = 1;
         end
         full_address_mode: begin
            ea = {memf(pc + 16'h0001), memf(pc + 16'h0002)};
            fetch = 2;
            len = 3;
         end
         pointer_mode: begin
            ea = {8'h00, idx};
            len = 1;
         end
         default: len = 2;
      endcase
      @(posedge i_clk);
      #1;
      i_pc_load = 1'b1;
      i_pc_value = pc;
      @(posedge i_clk);
      #1;
      i_pc_load = 1'b0;
      i_start = 1'b1;
      i_mode = m;
      i_access = acc;
      i_index = idx;
      i_store_data = sd;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         i_start = 1'b0;
         n++;
      end while (o_done !== 1'b1 && n < 20);
      check(16'(n), 16'(2 + fetch + (acc == ACC_READ ? 2 : (acc == ACC_WRITE ? 1 : 0))));
      if (m != implied_mode) check(o_operand_address, ea);
      if (acc == ACC_READ) check({8'h00, o_operand}, {8'h00, memf(ea)});
      if (acc == ACC_WRITE) check(wr_addr, ea);
      if (acc == ACC_WRITE) check({8'h00, wr_data}, {8'h00, sd});
      @(posedge i_clk);
      #1;
      check(o_program_counter, pc + 16'(len));
   endtask : run

   // One flag update, then a look at the flags and result one cycle later.
   task automatic fl(input logic rs, input logic [4:0] st, tm, sm, cm, input cea_alu_kind_t k,
                     input logic [7:0] a, b, input logic ci, input logic [4:0] ef,
                     input logic [7:0] er);
      @(posedge i_clk);
      #1;
      i_flag_valid = 1'b1;
      i_flag_req = {rs, st, tm, sm, cm, k, a, b, ci, 8'h00, 1'b0};
      @(posedge i_clk);
      #1;
      i_flag_valid = 1'b0;
      check({11'h000, o_condition_flags}, {11'h000, ef});
      check({8'h00, o_result}, {8'h00, er});
   endtask : fl

   task automatic t_reset;
      check(o_program_counter, 16'h0000);
      check({11'h000, o_condition_flags}, 16'h0008);
      check({12'h000, o_busy, o_done, o_mem.rd, o_mem.wr}, 16'h0000);
      $display("test reset finished");
   endtask : t_reset

   // Reads in every mode that run models but implied, writes in four of them, across page and counter wrap boundaries.
   task automatic t_reads;
      run(implied_mode, ACC_NONE, 16'h0100, 8'h00, 8'h00);
      run(literal_operand_mode, ACC_READ, 16'h1234, 8'h00, 8'h00);
      run(direct_mode, ACC_READ, 16'h20fe, 8'h00, 8'h00);
      run(full_address_mode, ACC_READ, 16'hfffd, 8'h00, 8'h00);
      run(pointer_mode, ACC_READ, 16'h0200, 8'h80, 8'h00);
      run(bit_modify_mode, ACC_READ, 16'h0710, 8'h00, 8'h00);
      run(branch_offset_mode, ACC_READ, 16'h0820, 8'h00, 8'h00);
      run(pointer_mode, ACC_WRITE, 16'h0300, 8'hff, 8'ha5);
      run(full_address_mode, ACC_WRITE, 16'h0400, 8'h00, 8'h3c);
      run(literal_operand_mode, ACC_WRITE, 16'h0500, 8'h00, 8'h81);
      run(direct_mode, ACC_WRITE, 16'h06ff, 8'h00, 8'h42);
      $display("test reads and writes finished");
   endtask : t_reads

   // Half carry from add, zero and carry from add and borrow; mask left alone throughout.
   task automatic t_flag_arith;
      fl(1'b0, 5'h00, 5'h17, 5'h00, 5'h00, ALU_ADD, 8'h0f, 8'h01, 1'b0, 5'h18, 8'h10);
      fl(1'b0, 5'h00, 5'h17, 5'h00, 5'h00, ALU_ADD, 8'hff, 8'h01, 1'b0, 5'h1b, 8'h00);
      fl(1'b0, 5'h00, 5'h07, 5'h00, 5'h00, ALU_SUB, 8'h00, 8'h01, 1'b0, 5'h1d, 8'hff);
      $display("test flag arithmetic finished");
   endtask : t_flag_arith

   // Forced clear and set, then a restore that overrides tested bits.
   task automatic t_flag_force;
      fl(1'b0, 5'h00, 5'h00, 5'h00, 5'h09, ALU_OTHER, 8'h00, 8'h00, 1'b0, 5'h14, 8'h00);
      fl(1'b0, 5'h00, 5'h00, 5'h01, 5'h00, ALU_OTHER, 8'h00, 8'h00, 1'b0, 5'h15, 8'h00);
      fl(1'b1, 5'h0a, 5'h1f, 5'h00, 5'h00, ALU_ADD, 8'hff, 8'h01, 1'b0, 5'h0a, 8'h00);
      $display("test flag force finished");
   endtask : t_flag_force

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence: reset for eight cycles, then every scenario in turn.
   initial begin
      i_rst_n = 1'b0;
      i_start = 1'b0;
      i_pc_load = 1'b0;
      i_pc_value = 16'h0000;
      i_flag_valid = 1'b0;
      i_mode = implied_mode;
      i_access = ACC_NONE;
      i_store_data = 8'h00;
      i_index = 8'h00;
      i_flag_req = '0;
      repeat (8) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      t_reset();
      t_reads();
      t_flag_arith();
      t_flag_force();
      tally_and_finish();
   end

   // The run needs about 100 cycles; a hang ends it at 2500 cycles, well beyond that.
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
endmodule : cpu_effective_address_and_flags_tb_top
`default_nettype wire
